// file: gsa_pkg.sv
// Constants, types and register map of the generator start and auxiliary relay controller
package gsa_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int TENTH_S_NS = 100_000_000;
	localparam int TICK_CYC = (TENTH_S_NS + CLK_NS - 1) / CLK_NS;
	localparam int ABSORB_S = 7200;
	localparam int ABSORB_TICKS = ABSORB_S * 10;
	localparam logic [4:0] AUX_CLOSE_TICKS = 5'h14;
	localparam logic [4:0] AUX_OPEN_TICKS = 5'h01;
	localparam logic [7:0] XFER_TICKS = 8'hc8;
	localparam logic [7:0] STOP_PULSE_S = 8'h05;
	localparam logic [7:0] WARMUP_MIN_S = 8'h10;
	localparam logic [2:0] MAX_ATTEMPTS = 3'h5;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GEN_TIME = 8'h04;
	localparam logic [7:0] OFS_AUX0 = 8'h08;
	localparam logic [7:0] OFS_AUX1 = 8'h0c;
	localparam logic [7:0] OFS_AUX2 = 8'h10;
	localparam logic [7:0] OFS_BATT_LIM = 8'h14;
	localparam logic [7:0] OFS_BATT_CUT = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_GLOW_BIT = 0;
	localparam int CTRL_GEN_REQ_BIT = 1;
	localparam int CTRL_INV_EN_BIT = 2;
	localparam int CTRL_GRID_LSB = 4;
	localparam int GT_WARM_LSB = 0;
	localparam int GT_PRE_LSB = 8;
	localparam int GT_CRANK_LSB = 16;
	localparam int GT_POST_LSB = 24;
	localparam int HI_LSB = 16;
	// ----------------------------------------------------------------
	// Reset values (voltages in millivolts, bulk time in 10 minute units)
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_WARMUP = 8'h3c;
	localparam logic [7:0] RST_PRECRANK = 8'h0a;
	localparam logic [3:0] RST_MAXCRANK = 4'ha;
	localparam logic [7:0] RST_POSTCRANK = 8'h1e;
	localparam logic [15:0] RST_AUX_SETPT = 16'h38a4;
	localparam logic [15:0] RST_AUX_HYST = 16'h03e8;
	localparam logic [15:0] RST_XFER_MV = 16'h2c24;
	localparam logic [15:0] RST_CUTIN_MV = 16'h30d4;
	localparam logic [15:0] RST_CUTOUT_MV = 16'h2af8;
	localparam logic [7:0] RST_BULK_TIME = 8'h00;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		GSA_IDLE = 3'h0, GSA_PRE = 3'h1, GSA_CRANK = 3'h3, GSA_POST = 3'h2,
		GSA_WARM = 3'h6, GSA_RUN = 3'h7, GSA_STOP = 3'h5, GSA_FAIL = 3'h4
	} gsa_gen_e;
	typedef enum logic [1:0] {
		GSA_SILENT = 2'h0, GSA_LOW_BATT_XFER = 2'h1, GSA_FLOAT = 2'h2, GSA_SELL = 2'h3
	} gsa_grid_e;
endpackage : gsa_pkg

// file: gsa_aux_if.sv
// Bundle between the controller and its auxiliary relay bank
`timescale 1ns/1ns
interface gsa_aux_if #(parameter int N = 3);
	logic [N-1:0][15:0] setpt;
	logic [N-1:0][15:0] hyst;
	logic [15:0] comp;
	logic [15:0] batt_mv;
	logic tick;
	logic [N-1:0] relay;
	modport ctl (output setpt, output hyst, output comp, output batt_mv, output tick, input relay);
	modport aux (input setpt, input hyst, input comp, input batt_mv, input tick, output relay);
endinterface : gsa_aux_if

// file: gsa_aux_relays.sv
// Bank of battery-voltage auxiliary relays with hysteresis and switching delays
`timescale 1ns/1ns
module gsa_aux_relays
	import gsa_pkg::*;
#(
	parameter int N = 3
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	gsa_aux_if.aux ax
);
	typedef struct packed {
		logic [N-1:0] on;
		logic [N-1:0][4:0] dly;
	} gsa_aux_s;

	gsa_aux_s st;
	gsa_aux_s nxt;

	// ----------------------------------------------------------------
	// Per-relay comparison and delay
	// ----------------------------------------------------------------
	always_comb begin
		logic signed [17:0] sp_eff;
		logic signed [17:0] lo_eff;
		logic signed [17:0] v;
		logic want;
		sp_eff = '0;
		lo_eff = '0;
		v = $signed({2'h0, ax.batt_mv});
		want = 1'b0;
		nxt = st;
		for (int i = 0; i < N; i++) begin
			sp_eff = $signed({2'h0, ax.setpt[i]}) + $signed({{2{ax.comp[15]}}, ax.comp});
			lo_eff = sp_eff - $signed({2'h0, ax.hyst[i]});
			want = st.on[i] ? !(v < lo_eff) : (v > sp_eff);
			if (want == st.on[i]) begin
				nxt.dly[i] = 5'h00;
			end else if (ax.tick) begin
				// Change must persist for the whole delay or it is forgotten
				if (st.dly[i] + 5'h01 >= (want ? AUX_CLOSE_TICKS : AUX_OPEN_TICKS)) begin
					nxt.on[i] = want;
					nxt.dly[i] = 5'h00;
				end else begin
					nxt.dly[i] = st.dly[i] + 5'h01;
				end
			end
		end
	end

	// Runs from the controller clock and clock enable, whatever the inverter state
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else if (clk_en) begin
			st <= nxt;
		end
	end

	assign ax.relay = st.on;

	close_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(st.on[0]) |-> $past(st.dly[0]) == AUX_CLOSE_TICKS - 5'h01)
		else $error("aux relay closed without two second delay");
	open_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(st.on[1]) |-> $past(st.dly[1]) == AUX_OPEN_TICKS - 5'h01)
		else $error("aux relay opened with wrong delay");
endmodule : gsa_aux_relays

// file: gsa_gen_ctrl.sv
// Generator start sequencer, low-battery transfer, bulk trigger and APB registers
`timescale 1ns/1ns
module gsa_gen_ctrl
	import gsa_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int ABSORB_TENTHS = ABSORB_TICKS
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] batt_mv,
	input wire logic [15:0] temp_comp,
	input wire logic battery_temp_sensor,
	input wire logic gen_running,
	input wire logic utility_input,
	input wire logic [7:0] tod_10min,
	input wire logic absorb_reached,
	output logic gen_function_relay,
	output logic starter_crank_relay,
	output logic [2:0] aux_relay,
	output logic gen_load_connect,
	output logic gen_start_failed,
	output logic load_to_utility,
	output logic inverter_on,
	output logic bulk_start,
	output logic absorb_hold
);
	typedef struct packed {
		logic [2:0] sy_run;
		logic [2:0] sy_sens;
		logic [2:0] sy_util;
		logic run_s;
		logic sens_s;
		logic util_s;
		logic [31:0] tick_cnt;
		logic tick;
		logic glow;
		logic gen_req;
		logic inv_en;
		gsa_grid_e grid;
		logic [7:0] warm;
		logic [7:0] pre;
		logic [3:0] crank;
		logic [7:0] post;
		logic [2:0][15:0] setpt;
		logic [2:0][15:0] hyst;
		logic [15:0] xfer_mv;
		logic [15:0] cutin_mv;
		logic [15:0] cutout_mv;
		logic [7:0] bulk_t;
		gsa_gen_e gst;
		logic [11:0] tmr;
		logic [2:0] tries;
		logic fn_rly;
		logic st_rly;
		logic failed;
		logic load_con;
		logic xfer;
		logic [7:0] xfer_cnt;
		logic cutout_trip;
		logic inv_on;
		logic [7:0] tod_prev;
		logic bulk_pls;
		logic bulk_arm;
		logic absorb;
		logic [16:0] abs_cnt;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} gsa_ctrl_s;

	gsa_ctrl_s st;
	gsa_ctrl_s nxt;

	gsa_aux_if #(.N(3)) aux_bus ();

	// Seconds setting to tenth-second ticks
	function automatic logic [11:0] sec10(input logic [7:0] s);
		return {1'b0, s, 3'h0} + {3'h0, s, 1'h0};
	endfunction : sec10

	function automatic logic reg_hit(input logic [7:0] a);
		return a <= OFS_STATUS && a[1:0] == 2'h0;
	endfunction : reg_hit

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] warm_eff;
		logic acc;
		logic wr;
		warm_eff = (st.warm < WARMUP_MIN_S) ? WARMUP_MIN_S : st.warm;
		acc = psel && penable;
		wr = acc && st.pready && pwrite && reg_hit(paddr);
		nxt = st;
		// Three-stage pin synchronisers, a change counts when stages two and three agree
		nxt.sy_run = {st.sy_run[1:0], gen_running};
		nxt.sy_sens = {st.sy_sens[1:0], battery_temp_sensor};
		nxt.sy_util = {st.sy_util[1:0], utility_input};
		if (st.sy_run[1] == st.sy_run[2]) nxt.run_s = st.sy_run[2];
		if (st.sy_sens[1] == st.sy_sens[2]) nxt.sens_s = st.sy_sens[2];
		if (st.sy_util[1] == st.sy_util[2]) nxt.util_s = st.sy_util[2];
		nxt.tick = 1'b0;
		nxt.tick_cnt = st.tick_cnt + 32'h1;
		if (st.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			nxt.tick_cnt = '0;
			nxt.tick = 1'b1;
		end
		// ------------------------------------------------------------
		// APB slave: one wait state, registered answer
		// ------------------------------------------------------------
		nxt.pready = acc && !st.pready;
		nxt.pslverr = acc && !st.pready && !reg_hit(paddr);
		if (acc && !st.pready) begin
			unique case (paddr)
				OFS_CTRL: nxt.prdata = 32'({st.grid, 1'b0, st.inv_en, st.gen_req, st.glow});
				OFS_GEN_TIME: nxt.prdata = {st.post, 4'h0, st.crank, st.pre, st.warm};
				OFS_AUX0: nxt.prdata = {st.hyst[0], st.setpt[0]};
				OFS_AUX1: nxt.prdata = {st.hyst[1], st.setpt[1]};
				OFS_AUX2: nxt.prdata = {st.hyst[2], st.setpt[2]};
				OFS_BATT_LIM: nxt.prdata = {st.cutin_mv, st.xfer_mv};
				OFS_BATT_CUT: nxt.prdata = {8'h00, st.bulk_t, st.cutout_mv};
				OFS_STATUS: nxt.prdata = 32'({st.gst == GSA_FAIL, st.run_s, st.absorb, st.inv_on,
					st.xfer, aux_bus.relay, st.tries, st.gst});
				default: nxt.prdata = 32'h0;
			endcase
		end
		if (wr) begin
			unique case (paddr)
				OFS_CTRL: begin
					nxt.glow = pwdata[CTRL_GLOW_BIT];
					nxt.gen_req = pwdata[CTRL_GEN_REQ_BIT];
					nxt.inv_en = pwdata[CTRL_INV_EN_BIT];
					nxt.grid = gsa_grid_e'(pwdata[CTRL_GRID_LSB +: 2]);
				end
				OFS_GEN_TIME: begin
					nxt.warm = pwdata[GT_WARM_LSB +: 8];
					nxt.pre = pwdata[GT_PRE_LSB +: 8];
					nxt.crank = pwdata[GT_CRANK_LSB +: 4];
					nxt.post = pwdata[GT_POST_LSB +: 8];
				end
				OFS_AUX0: {nxt.hyst[0], nxt.setpt[0]} = pwdata;
				OFS_AUX1: {nxt.hyst[1], nxt.setpt[1]} = pwdata;
				OFS_AUX2: {nxt.hyst[2], nxt.setpt[2]} = pwdata;
				OFS_BATT_LIM: {nxt.cutin_mv, nxt.xfer_mv} = pwdata;
				OFS_BATT_CUT: {nxt.bulk_t, nxt.cutout_mv} = pwdata[23:0];
				default: ;
			endcase
		end
		// ------------------------------------------------------------
		// Generator start sequencer
		// ------------------------------------------------------------
		if (st.tick) nxt.tmr = st.tmr + 12'h001;
		unique case (st.gst)
			GSA_IDLE: begin
				if (st.gen_req) begin
					nxt.gst = st.run_s ? GSA_WARM : GSA_PRE;
					nxt.tries = 3'h1;
				end
			end
			GSA_PRE: begin
				if (!st.gen_req) nxt.gst = GSA_IDLE;
				else if (st.tmr >= sec10(st.pre)) nxt.gst = GSA_CRANK;
			end
			GSA_CRANK: begin
				if (st.run_s) nxt.gst = GSA_WARM;
				else if (!st.gen_req || st.tmr >= sec10({4'h0, st.crank})) nxt.gst = GSA_POST;
			end
			GSA_POST: begin
				if (st.run_s) begin
					nxt.gst = GSA_WARM;
				end else if (!st.gen_req) begin
					nxt.gst = GSA_IDLE;
				end else if (st.tmr >= sec10(st.post)) begin
					// Give up after the fifth failed attempt
					if (st.tries < MAX_ATTEMPTS) begin
						nxt.gst = GSA_PRE;
						nxt.tries = st.tries + 3'h1;
					end else begin
						nxt.gst = GSA_FAIL;
					end
				end
			end
			GSA_WARM: begin
				if (!st.gen_req || !st.run_s) nxt.gst = GSA_STOP;
				else if (st.tmr >= sec10(warm_eff)) nxt.gst = GSA_RUN;
			end
			GSA_RUN: begin
				if (!st.gen_req || !st.run_s) nxt.gst = GSA_STOP;
			end
			GSA_STOP: begin
				if (st.tmr >= sec10(STOP_PULSE_S)) nxt.gst = GSA_IDLE;
			end
			GSA_FAIL: begin
				if (!st.gen_req) nxt.gst = GSA_IDLE;
			end
		endcase
		if (nxt.gst != st.gst) nxt.tmr = '0;
		// Follow a fresh function write at once so relay and setting never disagree
		if (nxt.glow) begin
			// One output serves as preheat before cranking and as stop pulse
			nxt.fn_rly = nxt.gst == GSA_PRE || nxt.gst == GSA_STOP;
		end else begin
			nxt.fn_rly = nxt.gst inside {GSA_PRE, GSA_CRANK, GSA_POST, GSA_WARM, GSA_RUN};
		end
		nxt.st_rly = nxt.gst == GSA_CRANK;
		nxt.load_con = nxt.gst == GSA_RUN;
		nxt.failed = nxt.gst == GSA_FAIL;
		// ------------------------------------------------------------
		// Low-battery transfer and inverter cut-out, uncompensated
		// ------------------------------------------------------------
		if (!(st.grid inside {GSA_LOW_BATT_XFER, GSA_FLOAT}) || !st.util_s) begin
			nxt.xfer = 1'b0;
			nxt.xfer_cnt = '0;
		end else if (st.xfer) begin
			if (batt_mv >= st.cutin_mv) nxt.xfer = 1'b0;
			nxt.xfer_cnt = '0;
		end else if (batt_mv >= st.xfer_mv) begin
			nxt.xfer_cnt = '0;
		end else if (st.tick) begin
			nxt.xfer_cnt = st.xfer_cnt + 8'h01;
			if (st.xfer_cnt + 8'h01 >= XFER_TICKS) nxt.xfer = 1'b1;
		end
		if (batt_mv < st.cutout_mv) nxt.cutout_trip = 1'b1;
		else if (batt_mv >= st.cutin_mv) nxt.cutout_trip = 1'b0;
		nxt.inv_on = st.inv_en && !nxt.cutout_trip;
		// ------------------------------------------------------------
		// Daily bulk trigger and absorption hold
		// ------------------------------------------------------------
		nxt.tod_prev = tod_10min;
		nxt.bulk_pls = st.bulk_t != 8'h00 && tod_10min == st.bulk_t && st.tod_prev != tod_10min
			&& st.util_s;
		if (st.bulk_arm && absorb_reached) begin
			nxt.bulk_arm = 1'b0;
			nxt.absorb = 1'b1;
			nxt.abs_cnt = '0;
		end else if (st.absorb && st.tick) begin
			nxt.abs_cnt = st.abs_cnt + 17'h00001;
			if (st.abs_cnt >= 17'(ABSORB_TENTHS - 1)) nxt.absorb = 1'b0;
		end
		// A new trigger wins over consuming the old one in the same cycle
		if (nxt.bulk_pls) nxt.bulk_arm = 1'b1;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.glow <= 1'b0;
			st.grid <= GSA_SILENT;
			st.gst <= GSA_IDLE;
			st.warm <= RST_WARMUP;
			st.pre <= RST_PRECRANK;
			st.crank <= RST_MAXCRANK;
			st.post <= RST_POSTCRANK;
			st.setpt <= {3{RST_AUX_SETPT}};
			st.hyst <= {3{RST_AUX_HYST}};
			st.xfer_mv <= RST_XFER_MV;
			st.cutin_mv <= RST_CUTIN_MV;
			st.cutout_mv <= RST_CUTOUT_MV;
			st.bulk_t <= RST_BULK_TIME;
		end else if (clk_en) begin
			st <= nxt;
		end
	end

	// ----------------------------------------------------------------
	// Auxiliary relay bank
	// ----------------------------------------------------------------
	assign aux_bus.setpt = st.setpt;
	assign aux_bus.hyst = st.hyst;
	assign aux_bus.comp = st.sens_s ? temp_comp : 16'h0000;
	assign aux_bus.batt_mv = batt_mv;
	assign aux_bus.tick = st.tick;

	gsa_aux_relays #(.N(3)) u_aux (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.ax(aux_bus.aux)
	);

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign gen_function_relay = st.fn_rly;
	assign starter_crank_relay = st.st_rly;
	assign aux_relay = aux_bus.relay;
	assign gen_load_connect = st.load_con;
	assign gen_start_failed = st.failed;
	assign load_to_utility = st.xfer;
	assign inverter_on = st.inv_on;
	assign bulk_start = st.bulk_pls;
	assign absorb_hold = st.absorb;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	reset_run_a: assert property ($rose(rst_b) |-> !st.glow)
		else $error("function relay not in run choice after reset");
	run_closed_a: assert property (!st.glow && st.gst == GSA_RUN |-> gen_function_relay)
		else $error("run function relay open while running");
	glow_open_a: assert property (st.glow && st.gst inside {GSA_RUN, GSA_WARM} |-> !gen_function_relay)
		else $error("stop relay closed while running");
	glow_preheat_a: assert property (st.glow && st.gst == GSA_PRE |-> gen_function_relay)
		else $error("no preheat before cranking");
	precrank_wait_a: assert property ($rose(starter_crank_relay) |-> $past(st.tmr) >= sec10($past(st.pre)))
		else $error("starter closed before pre-crank delay");
	crank_limit_a: assert property (starter_crank_relay |-> st.tmr <= sec10({4'h0, st.crank}))
		else $error("starter held past maximum cranking time");
	attempt_cap_a: assert property (st.tries <= MAX_ATTEMPTS)
		else $error("more than five start attempts");
	crank_abort_a: assert property (clk_en && st.gst == GSA_CRANK && st.run_s |=> !starter_crank_relay)
		else $error("starter not released once generator runs");
	xfer_delay_a: assert property ($rose(load_to_utility) |-> $past(st.xfer_cnt) == XFER_TICKS - 8'h01)
		else $error("transfer without twenty seconds low");
	bulk_off_a: assert property (clk_en && st.bulk_t == 8'h00 |=> !bulk_start)
		else $error("bulk start while trigger disabled");
	cutin_restart_a: assert property ($rose(inverter_on) && $past(st.cutout_trip) |-> $past(batt_mv) >= $past(st.cutin_mv))
		else $error("inverter restarted below cut-in");
endmodule : gsa_gen_ctrl

// file: gsa_gen_model.sv
// Behavioural generator that catches after a set cranking effort and obeys the stop signal
`timescale 1ns/1ns
module gsa_gen_model (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic gen_function_relay,
	input wire logic starter_crank_relay,
	input wire logic glow_mode,
	input wire logic [2:0] start_on,
	input wire logic [15:0] crank_need,
	output logic gen_running
);
	int n_att;
	int n_cr;
	logic st_q;
	logic fr_q;
	// ----------------------------------------------------------------
	// Engine
	// ----------------------------------------------------------------
	// Catches from attempt start_on onwards, after crank_need cycles of cranking; 0 never catches
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			n_att <= 0;
			n_cr <= 0;
			st_q <= 1'b0;
			fr_q <= 1'b0;
			gen_running <= 1'b0;
		end else begin
			st_q <= starter_crank_relay;
			fr_q <= gen_function_relay;
			n_cr <= starter_crank_relay ? n_cr + 1 : 0;
			if (starter_crank_relay && !st_q)
				n_att <= n_att + 1;
			if (starter_crank_relay && start_on != 3'h0 && n_att >= start_on && n_cr >= crank_need)
				gen_running <= 1'b1;
			// Run wiring stops on relay release, stop wiring on relay pull-in
			if (gen_running && (glow_mode ? (gen_function_relay && !fr_q) : (!gen_function_relay && fr_q))) begin
				gen_running <= 1'b0;
				n_att <= 0;
			end
		end
	end
endmodule : gsa_gen_model

// file: gen_start_aux_relay_control_bench.sv
// Self-checking bench for the generator start and auxiliary relay controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
`define WAIT(c, lim) begin n_cyc = 0; while (!(c) && n_cyc < lim) begin @(posedge clk_sys); n_cyc++; end end
module gen_start_aux_relay_control_bench;
	import gsa_pkg::*;
	localparam int TK = 10;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} gsa_row_s;
	logic clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, tod_10min = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, sensor = 1'b0, utility = 1'b0, absorb_reached = 1'b0, glow = 1'b0, st_q = 1'b0;
	logic [15:0] batt_mv = 16'h3200, temp_comp = 16'h0000, crank_need = 16'h0064;
	logic [2:0] start_on = 3'h2, aux_relay;
	logic gen_running, gen_function_relay, starter_crank_relay, gen_load_connect, gen_start_failed;
	logic load_to_utility, inverter_on, bulk_start, absorb_hold;
	int n_fail = 0, n_tests = 0, n_cyc, n_crank = 0, n_bulk = 0, c0;
	gsa_row_s rows [0:7];
	// ----------------------------------------------------------------
	// Design, generator and clock
	// ----------------------------------------------------------------
	gsa_gen_ctrl #(.TICK_CYCLES(TK), .ABSORB_TENTHS(50)) u_gsa_gen_ctrl (
		.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.batt_mv(batt_mv), .temp_comp(temp_comp), .battery_temp_sensor(sensor), .gen_running(gen_running),
		.utility_input(utility), .tod_10min(tod_10min), .absorb_reached(absorb_reached),
		.gen_function_relay(gen_function_relay), .starter_crank_relay(starter_crank_relay),
		.aux_relay(aux_relay), .gen_load_connect(gen_load_connect), .gen_start_failed(gen_start_failed),
		.load_to_utility(load_to_utility), .inverter_on(inverter_on), .bulk_start(bulk_start),
		.absorb_hold(absorb_hold));
	gsa_gen_model u_gsa_gen_model (.clk_sys(clk_sys), .rst_b(rst_b), .gen_function_relay(gen_function_relay),
		.starter_crank_relay(starter_crank_relay), .glow_mode(glow), .start_on(start_on),
		.crank_need(crank_need), .gen_running(gen_running));
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		st_q <= starter_crank_relay;
		if (starter_crank_relay === 1'b1 && st_q !== 1'b1)
			n_crank++;
		if (bulk_start === 1'b1)
			n_bulk++;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic logic inr(input int v, input int lo, input int hi);
		return v >= lo && v <= hi;
	endfunction : inr
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic ctrl(input logic g, input logic r, input logic v, input logic [1:0] m);
		apb(1'b1, OFS_CTRL, {26'h0, m, 1'b0, v, r, g});
	endtask : ctrl
	task automatic print_verdict();
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_fail++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		rows = '{'{OFS_GEN_TIME, {RST_POSTCRANK, 4'h0, RST_MAXCRANK, RST_PRECRANK, RST_WARMUP}, 1'b0},
			'{OFS_AUX0, {RST_AUX_HYST, RST_AUX_SETPT}, 1'b0}, '{OFS_AUX1, {RST_AUX_HYST, RST_AUX_SETPT}, 1'b0},
			'{OFS_AUX2, {RST_AUX_HYST, RST_AUX_SETPT}, 1'b0}, '{OFS_BATT_LIM, {RST_CUTIN_MV, RST_XFER_MV}, 1'b0},
			'{OFS_BATT_CUT, {8'h00, RST_BULK_TIME, RST_CUTOUT_MV}, 1'b0}, '{8'h20, 32'h0, 1'b1}, '{8'h06, 32'h0, 1'b1}};
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk_sys);
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK("ctrl_fn_mode", 1'b0, rd[CTRL_GLOW_BIT])
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, 32'h0);
			`CHK("reg_value", rows[i].d, rd)
			`CHK("reg_err", rows[i].e, er)
		end
		apb(1'b1, 8'h06, 32'hffffffff);
		`CHK("unaligned_err", 1'b1, er)
		apb(1'b1, OFS_GEN_TIME, {8'h02, 4'h0, 4'h3, 8'h02, 8'h10});
		// Run wiring: first attempt cranks in full, second catches mid-crank
		ctrl(1'b0, 1'b1, 1'b1, 2'h0);
		`WAIT(gen_function_relay === 1'b1, 100)
		`WAIT(starter_crank_relay === 1'b1, 400)
		`CHK("pre_crank", 1'b1, inr(n_cyc, 189, 212))
		`WAIT(starter_crank_relay === 1'b0, 400)
		`CHK("max_crank", 1'b1, inr(n_cyc, 289, 312))
		`CHK("fn_held", 1'b1, gen_function_relay)
		`WAIT(starter_crank_relay === 1'b1, 500)
		`CHK("post_crank", 1'b1, inr(n_cyc, 389, 415))
		`WAIT(starter_crank_relay === 1'b0, 400)
		`CHK("crank_abort", 1'b1, inr(n_cyc, 100, 130))
		`WAIT(gen_load_connect === 1'b1, 2000)
		`CHK("warmup", 1'b1, inr(n_cyc, 1585, 1625))
		`CHK("fn_running", 1'b1, gen_function_relay)
		ctrl(1'b0, 1'b0, 1'b1, 2'h0);
		`WAIT(gen_function_relay === 1'b0, 100)
		`CHK("fn_off", 1'b1, n_cyc < 100)
		repeat (700) @(posedge clk_sys);
		// Preheat-stop wiring: relay for preheat, open while running, then a stop pulse
		glow <= 1'b1;
		start_on <= 3'h1;
		crank_need <= 16'h0032;
		ctrl(1'b1, 1'b1, 1'b1, 2'h0);
		`WAIT(gen_function_relay === 1'b1, 100)
		`CHK("preheat", 1'b1, n_cyc < 100)
		`WAIT(starter_crank_relay === 1'b1, 400)
		`CHK("pre_crank_glow", 1'b1, inr(n_cyc, 189, 212))
		`WAIT(gen_load_connect === 1'b1, 2000)
		`CHK("fn_open_run", 1'b0, gen_function_relay)
		ctrl(1'b1, 1'b0, 1'b1, 2'h0);
		`WAIT(gen_function_relay === 1'b1, 100)
		`CHK("stop_start", 1'b1, n_cyc < 100)
		`WAIT(gen_function_relay === 1'b0, 700)
		`CHK("stop_len", 1'b1, inr(n_cyc, 485, 515))
		repeat (50) @(posedge clk_sys);
		// Generator never catches: five attempts, then failure
		glow <= 1'b0;
		start_on <= 3'h0;
		c0 = n_crank;
		ctrl(1'b0, 1'b1, 1'b0, 2'h0);
		`WAIT(gen_start_failed === 1'b1, 4200)
		`CHK("attempts", 5, n_crank - c0)
		ctrl(1'b0, 1'b0, 1'b0, 2'h0);
		// Aux relays with the inverter disabled, one setpoint lowered
		apb(1'b1, OFS_AUX1, {16'h03e8, 16'h36b0});
		batt_mv <= 16'h3778;
		`WAIT(aux_relay !== 3'h0, 300)
		`CHK("aux_close", 3'h2, aux_relay)
		`CHK("aux_close_dly", 1'b1, inr(n_cyc, 185, 225))
		batt_mv <= 16'h3908;
		`WAIT(aux_relay === 3'h7, 300)
		`CHK("aux_all", 3'h7, aux_relay)
		batt_mv <= 16'h3520;
		repeat (300) @(posedge clk_sys);
		`CHK("aux_hyst", 3'h7, aux_relay)
		batt_mv <= 16'h34b8;
		`WAIT(aux_relay === 3'h2, 100)
		`CHK("aux_open_dly", 1'b1, n_cyc <= 25)
		sensor <= 1'b1;
		temp_comp <= 16'h0190;
		batt_mv <= 16'h3908;
		repeat (300) @(posedge clk_sys);
		`CHK("aux_comp", 3'h2, aux_relay)
		sensor <= 1'b0;
		`WAIT(aux_relay === 3'h7, 300)
		`CHK("aux_nocomp", 3'h7, aux_relay)
		batt_mv <= 16'h3200;
		// Low-battery transfer, then cut-out and cut-in
		utility <= 1'b1;
		ctrl(1'b0, 1'b0, 1'b1, GSA_LOW_BATT_XFER);
		batt_mv <= 16'h2bc0;
		`WAIT(load_to_utility === 1'b1, 2300)
		`CHK("xfer_dly", 1'b1, inr(n_cyc, 1980, 2035))
		batt_mv <= 16'h3070;
		repeat (100) @(posedge clk_sys);
		`CHK("xfer_hold", 1'b1, load_to_utility)
		batt_mv <= 16'h30d4;
		`WAIT(load_to_utility === 1'b0, 50)
		`CHK("xfer_back", 1'b0, load_to_utility)
		ctrl(1'b0, 1'b0, 1'b1, GSA_SILENT);
		batt_mv <= 16'h2bc0;
		repeat (2300) @(posedge clk_sys);
		`CHK("xfer_silent", 1'b0, load_to_utility)
		batt_mv <= 16'h2a94;
		`WAIT(inverter_on === 1'b0, 50)
		`CHK("cutout", 1'b0, inverter_on)
		batt_mv <= 16'h2ee0;
		repeat (100) @(posedge clk_sys);
		`CHK("cutout_hold", 1'b0, inverter_on)
		batt_mv <= 16'h30d4;
		`WAIT(inverter_on === 1'b1, 50)
		`CHK("cutin", 1'b1, inverter_on)
		// Daily bulk trigger and absorption hold
		apb(1'b1, OFS_BATT_CUT, {8'h00, 8'h05, RST_CUTOUT_MV});
		tod_10min <= 8'h04;
		repeat (5) @(posedge clk_sys);
		c0 = n_bulk;
		tod_10min <= 8'h05;
		repeat (10) @(posedge clk_sys);
		`CHK("bulk_pulse", 1, n_bulk - c0)
		absorb_reached <= 1'b1;
		`WAIT(absorb_hold === 1'b1, 50)
		`WAIT(absorb_hold === 1'b0, 700)
		`CHK("absorb_len", 1'b1, inr(n_cyc, 490, 515))
		absorb_reached <= 1'b0;
		utility <= 1'b0;
		tod_10min <= 8'h04;
		repeat (5) @(posedge clk_sys);
		tod_10min <= 8'h05;
		repeat (10) @(posedge clk_sys);
		`CHK("bulk_no_util", 1, n_bulk - c0)
		utility <= 1'b1;
		apb(1'b1, OFS_BATT_CUT, {8'h00, 8'h00, RST_CUTOUT_MV});
		tod_10min <= 8'h00;
		repeat (10) @(posedge clk_sys);
		`CHK("bulk_off", 1, n_bulk - c0)
		// Clock enable low must freeze the cut-out decision
		clk_en <= 1'b0;
		batt_mv <= 16'h2a94;
		repeat (50) @(posedge clk_sys);
		`CHK("frozen", 1'b1, inverter_on)
		clk_en <= 1'b1;
		`WAIT(inverter_on === 1'b0, 50)
		`CHK("thawed", 1'b0, inverter_on)
		print_verdict();
	end
endmodule : gen_start_aux_relay_control_bench
